// ===== rtl/lpmc_top.sv
// Measurement path configuration: gain, range, hysteresis, persistence and result offset.
// Functional notes
// (R1) Visible integration time is stretched by two to the power of the 3-bit gain code.
// (R2) The same gain code divides the converter clock by two to the power of the code.
// (R3) Older sequencer revisions reuse the visible gain and range for infrared measurements.
// (R4) Bit 5 of the visible misc register selects the high signal range for visible light.
// (R5) The ambient margin, expanded, widens both the lower and the upper ambient limit.
// (R6) The proximity margin, expanded, widens all three proximity channel limits.
// (R7) A proximity status changes only after the masked run of consecutive samples agrees.
// (R8) An ambient status changes only after the masked run of consecutive samples agrees.
// (R9) The expanded bias code is added to every reported measurement; the block leaves it off overrange samples, which report 0xFFFF.
// (R10) The result 0xFFFF is kept for overrange; ordinary sums never reach it.
// (R11) Bias codes 0x60, 0x70 and 0x80 give offsets of 64, 128 and 256.
// (R12) Software should program the visible settle period as the inverse of the gain code.
// (R13) One shared expander decodes every compressed parameter; the block instead instantiates lpmc_expand three times, one per parameter.
// (R14) Software writes zero to reserved bits and ignores their read value.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "lpmc_defines.svh"
module lpmc_top #(
  parameter bit SEPARATE_IR_SETTINGS = 1'b1
) (
  input  wire logic                   clk_sys_in,
  input  wire logic                   reset_in,
  input  wire logic [7:0]             reg_addr_in,
  input  wire logic [7:0]             reg_wdata_in,
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  output logic      [7:0]             reg_rdata_out,
  input  wire lpmc_pkg::lpmc_meas_e   meas_kind_in,
  input  wire logic [2:0]             ir_gain_code_in,
  input  wire logic                   ir_high_span_in,
  input  wire lpmc_pkg::lpmc_sample_s sample_in,
  input  wire logic                   sample_valid_in,
  input  wire lpmc_pkg::lpmc_limits_s limits_in,
  output logic                        adc_tick_out,
  output logic      [2:0]             gain_exp_out,
  output logic                        high_range_out,
  output logic      [15:0]            result_out,
  output logic                        result_valid_out,
  output logic      [4:0]             status_out
);
  localparam int NUM_STATUS = 5;

  lpmc_pkg::lpmc_state_s st;
  lpmc_pkg::lpmc_state_s next_st;

  // Expanded values: 0 ambient margin, 1 proximity margin, 2 result bias.
  logic [2:0][7:0]  exp_code;
  logic [2:0][15:0] exp_value;

  logic [2:0]  sel_gain;
  logic        sel_span;
  logic [6:0]  div_limit;
  logic [16:0] biased;

  logic [NUM_STATUS-1:0]        stat_sample;
  logic [NUM_STATUS-1:0]        stat_exceed;
  logic [NUM_STATUS-1:0]        stat_recede;
  logic [NUM_STATUS-1:0][7:0]   stat_mask;
  logic [NUM_STATUS-1:0][15:0]  stat_limit;
  logic [NUM_STATUS-1:0][15:0]  stat_margin;
  logic [NUM_STATUS-1:0]        stat_is_lower;
  logic [NUM_STATUS-1:0]        stat_value;

  assign exp_code[0] = st.regs.ambient_threshold_margin;
  assign exp_code[1] = st.regs.proximity_threshold_margin;
  assign exp_code[2] = st.regs.measurement_bias_code;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_expand
      lpmc_expand u_expand ( // R13
        .code_in   (exp_code[gi]),
        .value_out (exp_value[gi])
      );
    end
  endgenerate

  // Status 0 upper ambient, 1 lower ambient, 2..4 proximity channels 1..3.
  always_comb begin
    stat_limit[0]    = limits_in.ambient_upper_limit;
    stat_limit[1]    = limits_in.ambient_lower_limit;
    stat_limit[2]    = limits_in.proximity_ch1_limit;
    stat_limit[3]    = limits_in.proximity_ch2_limit;
    stat_limit[4]    = limits_in.proximity_ch3_limit;
    stat_margin[0]   = exp_value[0]; // R5
    stat_margin[1]   = exp_value[0]; // R5
    stat_margin[2]   = exp_value[1]; // R6
    stat_margin[3]   = exp_value[1]; // R6
    stat_margin[4]   = exp_value[1]; // R6
    stat_mask[0]     = st.regs.ambient_persistence; // R8
    stat_mask[1]     = st.regs.ambient_persistence; // R8
    stat_mask[2]     = st.regs.proximity_persistence; // R7
    stat_mask[3]     = st.regs.proximity_persistence; // R7
    stat_mask[4]     = st.regs.proximity_persistence; // R7
    stat_is_lower    = 5'h02;
    stat_sample[0]   = st.result_valid && (st.result_kind == lpmc_pkg::LPMC_MEAS_VIS);
    stat_sample[1]   = st.result_valid && (st.result_kind == lpmc_pkg::LPMC_MEAS_VIS);
    stat_sample[2]   = st.result_valid && (st.result_kind == lpmc_pkg::LPMC_MEAS_PS1);
    stat_sample[3]   = st.result_valid && (st.result_kind == lpmc_pkg::LPMC_MEAS_PS2);
    stat_sample[4]   = st.result_valid && (st.result_kind == lpmc_pkg::LPMC_MEAS_PS3);
  end

  generate
    for (gi = 0; gi < NUM_STATUS; gi++) begin : g_status
      logic [16:0] lim_plus;
      logic [16:0] res_plus;
      // Sums are one bit wider so a large margin never wraps into a false crossing.
      assign lim_plus = {1'b0, stat_limit[gi]} + {1'b0, stat_margin[gi]};
      assign res_plus = {1'b0, st.result} + {1'b0, stat_margin[gi]};
      always_comb begin
        if (stat_is_lower[gi]) begin
          stat_exceed[gi] = res_plus < {1'b0, stat_limit[gi]};
          stat_recede[gi] = {1'b0, st.result} > lim_plus;
        end else begin
          stat_exceed[gi] = {1'b0, st.result} > lim_plus;
          stat_recede[gi] = res_plus < {1'b0, stat_limit[gi]};
        end
      end
      lpmc_persist u_persist (
        .clk_sys_in (clk_sys_in),
        .reset_in   (reset_in),
        .sample_in  (stat_sample[gi]),
        .exceed_in  (stat_exceed[gi]),
        .recede_in  (stat_recede[gi]),
        .mask_in    (stat_mask[gi]),
        .status_out (stat_value[gi])
      );
    end
  endgenerate

  // Gain and range follow the measurement now running.
  always_comb begin
    case (meas_kind_in)
      lpmc_pkg::LPMC_MEAS_VIS: begin
        sel_gain = st.regs.visible_integration_scale; // R1
        sel_span = st.regs.visible_high_span_select; // R4
      end
      lpmc_pkg::LPMC_MEAS_IR: begin
        if (SEPARATE_IR_SETTINGS) begin
          sel_gain = ir_gain_code_in;
          sel_span = ir_high_span_in;
        end else begin
          // Older sequencers have no infrared settings of their own.
          sel_gain = st.regs.visible_integration_scale; // R3
          sel_span = st.regs.visible_high_span_select; // R3
        end
      end
      default: begin
        // Proximity kinds run at unity gain and normal range.
        sel_gain = 3'h0;
        sel_span = 1'b0;
      end
    endcase
    div_limit = 7'((8'h01 << sel_gain) - 8'h01); // R2
  end

  // Offset keeps subtracted results positive; 17 bits so the clamp sees any carry.
  assign biased = {1'b0, sample_in.raw} + {1'b0, exp_value[2]}; // R9 R11

  always_comb begin
    next_st              = st;
    next_st.rd_data      = 8'h00;
    next_st.result_valid = 1'b0;

    if (reg_wr_in) begin
      case (reg_addr_in)
        `LPMC_OFS_VIS_SCALE: begin
          next_st.regs.visible_integration_scale = reg_wdata_in[`LPMC_VIS_GAIN_MSB:0];
        end
        `LPMC_OFS_VIS_MISC: begin
          next_st.regs.visible_high_span_select = reg_wdata_in[`LPMC_VIS_SPAN_BIT];
        end
        `LPMC_OFS_AMB_MARGIN: begin
          next_st.regs.ambient_threshold_margin = reg_wdata_in;
        end
        `LPMC_OFS_PROX_MARGIN: begin
          next_st.regs.proximity_threshold_margin = reg_wdata_in;
        end
        `LPMC_OFS_PROX_PERSIST: begin
          next_st.regs.proximity_persistence = reg_wdata_in;
        end
        `LPMC_OFS_AMB_PERSIST: begin
          next_st.regs.ambient_persistence = reg_wdata_in;
        end
        `LPMC_OFS_BIAS_CODE: begin
          next_st.regs.measurement_bias_code = reg_wdata_in;
        end
        default: begin
        end
      endcase
    end

    if (reg_rd_in) begin
      case (reg_addr_in)
        `LPMC_OFS_VIS_SCALE: begin
          next_st.rd_data = {5'h00, st.regs.visible_integration_scale};
        end
        `LPMC_OFS_VIS_MISC: begin
          next_st.rd_data = {2'h0, st.regs.visible_high_span_select, 5'h00};
        end
        `LPMC_OFS_AMB_MARGIN: begin
          next_st.rd_data = st.regs.ambient_threshold_margin;
        end
        `LPMC_OFS_PROX_MARGIN: begin
          next_st.rd_data = st.regs.proximity_threshold_margin;
        end
        `LPMC_OFS_PROX_PERSIST: begin
          next_st.rd_data = st.regs.proximity_persistence;
        end
        `LPMC_OFS_AMB_PERSIST: begin
          next_st.rd_data = st.regs.ambient_persistence;
        end
        `LPMC_OFS_BIAS_CODE: begin
          next_st.rd_data = st.regs.measurement_bias_code;
        end
        default: begin
          next_st.rd_data = 8'h00;
        end
      endcase
    end

    // Converter clock enable: one tick every 2^gain system clocks.
    next_st.gain_exp   = sel_gain; // R1
    next_st.high_range = sel_span; // R4
    if (st.div_count >= div_limit) begin
      next_st.div_count = 7'h00;
      next_st.adc_tick  = 1'b1; // R2
    end else begin
      next_st.div_count = 7'(st.div_count + 7'h01);
      next_st.adc_tick  = 1'b0;
    end

    if (sample_valid_in) begin
      next_st.result_valid = 1'b1;
      next_st.result_kind  = sample_in.kind;
      if (sample_in.overrange) begin
        next_st.result = `LPMC_OVERRANGE; // R10
      end else if (biased >= {1'b0, `LPMC_OVERRANGE}) begin
        // A large raw value plus bias must not be mistaken for overrange.
        next_st.result = `LPMC_CLAMP_MAX; // R10
      end else begin
        next_st.result = biased[15:0]; // R9
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      st                                 <= '0;
      st.regs.visible_integration_scale  <= `LPMC_RST_VIS_SCALE;
      st.regs.visible_high_span_select   <= `LPMC_RST_VIS_SPAN;
      st.regs.ambient_threshold_margin   <= `LPMC_RST_MARGIN;
      st.regs.proximity_threshold_margin <= `LPMC_RST_MARGIN;
      st.regs.proximity_persistence      <= `LPMC_RST_PERSIST;
      st.regs.ambient_persistence        <= `LPMC_RST_PERSIST;
      st.regs.measurement_bias_code      <= `LPMC_RST_BIAS_CODE;
      st.result_kind                     <= lpmc_pkg::LPMC_MEAS_VIS;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_out    = st.rd_data;
  assign adc_tick_out     = st.adc_tick;
  assign gain_exp_out     = st.gain_exp;
  assign high_range_out   = st.high_range;
  assign result_out       = st.result;
  assign result_valid_out = st.result_valid;
  assign status_out       = stat_value;
endmodule : lpmc_top

// ===== rtl/lpmc_defines.svh
// Register offsets, field positions, reset values and result codes of the measure config block.
`ifndef LPMC_DEFINES_SVH
`define LPMC_DEFINES_SVH

`define LPMC_OFS_VIS_SCALE    8'h11
`define LPMC_OFS_VIS_MISC     8'h12
`define LPMC_OFS_AMB_MARGIN   8'h16
`define LPMC_OFS_PROX_MARGIN  8'h17
`define LPMC_OFS_PROX_PERSIST 8'h18
`define LPMC_OFS_AMB_PERSIST  8'h19
`define LPMC_OFS_BIAS_CODE    8'h1A
`define LPMC_OFS_SETTLE_SPARE 8'h1C

`define LPMC_VIS_GAIN_MSB     2
`define LPMC_VIS_SPAN_BIT     5

`define LPMC_RST_VIS_SCALE    3'h0
`define LPMC_RST_VIS_SPAN     1'h0
`define LPMC_RST_MARGIN       8'h48
`define LPMC_RST_PERSIST      8'h03
`define LPMC_RST_BIAS_CODE    8'h80

`define LPMC_OVERRANGE        16'hFFFF
`define LPMC_CLAMP_MAX        16'hFFFE
`define LPMC_EXP_UNITY        4'h4

`endif

// ===== rtl/lpmc_pkg.sv
// Types shared by the measure config block and its submodules.
package lpmc_pkg;

  // Kind of measurement the converter is running; Gray codes along the usual order.
  typedef enum logic [2:0] {
    LPMC_MEAS_VIS = 3'h0,
    LPMC_MEAS_IR  = 3'h1,
    LPMC_MEAS_PS1 = 3'h3,
    LPMC_MEAS_PS2 = 3'h2,
    LPMC_MEAS_PS3 = 3'h6
  } lpmc_meas_e;

  typedef struct packed {
    lpmc_meas_e  kind;
    logic        overrange;
    logic [15:0] raw;
  } lpmc_sample_s;

  typedef struct packed {
    logic [15:0] ambient_upper_limit;
    logic [15:0] ambient_lower_limit;
    logic [15:0] proximity_ch1_limit;
    logic [15:0] proximity_ch2_limit;
    logic [15:0] proximity_ch3_limit;
  } lpmc_limits_s;

  typedef struct packed {
    logic [2:0] visible_integration_scale;
    logic       visible_high_span_select;
    logic [7:0] ambient_threshold_margin;
    logic [7:0] proximity_threshold_margin;
    logic [7:0] proximity_persistence;
    logic [7:0] ambient_persistence;
    logic [7:0] measurement_bias_code;
  } lpmc_regs_s;

  typedef struct packed {
    lpmc_regs_s  regs;
    logic [7:0]  rd_data;
    logic [6:0]  div_count;
    logic        adc_tick;
    logic [2:0]  gain_exp;
    logic        high_range;
    lpmc_meas_e  result_kind;
    logic [15:0] result;
    logic        result_valid;
  } lpmc_state_s;

  typedef struct packed {
    logic [7:0] exceed_hist;
    logic [7:0] recede_hist;
    logic       status;
  } lpmc_persist_s;

endpackage : lpmc_pkg

// ===== rtl/lpmc_expand.sv
// Expander from the 8-bit compressed parameter format to a 16-bit value.
`timescale 1ns/1ps
`include "lpmc_defines.svh"
module lpmc_expand (
  input  wire logic [7:0]  code_in,
  output logic      [15:0] value_out
);
  logic [3:0]  exp_part;
  logic [15:0] mant;

  // Upper nibble is a power of two, lower nibble a fraction under an implied leading one.
  always_comb begin
    exp_part = code_in[7:4];
    mant     = {11'h000, 1'b1, code_in[3:0]};
    if (code_in == 8'h00) begin
      value_out = 16'h0000;
    end else if (exp_part >= `LPMC_EXP_UNITY) begin
      value_out = mant << 4'(exp_part - `LPMC_EXP_UNITY);
    end else begin
      value_out = mant >> 4'(`LPMC_EXP_UNITY - exp_part);
    end
  end
endmodule : lpmc_expand

// ===== rtl/lpmc_persist.sv
// Consecutive-sample persistence filter for one threshold status.
`timescale 1ns/1ps
module lpmc_persist (
  input  wire logic       clk_sys_in,
  input  wire logic       reset_in,
  input  wire logic       sample_in,
  input  wire logic       exceed_in,
  input  wire logic       recede_in,
  input  wire logic [7:0] mask_in,
  output logic            status_out
);
  lpmc_pkg::lpmc_persist_s st;
  lpmc_pkg::lpmc_persist_s next_st;

  // Each mask bit names one recent sample that must agree before the status moves.
  always_comb begin
    next_st = st;
    if (sample_in) begin
      next_st.exceed_hist = {st.exceed_hist[6:0], exceed_in};
      next_st.recede_hist = {st.recede_hist[6:0], recede_in};
      if ((next_st.exceed_hist & mask_in) == mask_in) begin
        next_st.status = 1'b1;
      end else if ((next_st.recede_hist & mask_in) == mask_in) begin
        next_st.status = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign status_out = st.status;
endmodule : lpmc_persist

// ===== verification/lpmc_checker.sv
// Port checker for the measurement path configuration block.
`timescale 1ns/1ps
module lpmc_checker (
  input wire logic                   clk_sys_in,
  input wire logic                   reset_in,
  input wire lpmc_pkg::lpmc_meas_e   meas_kind_in,
  input wire lpmc_pkg::lpmc_sample_s sample_in,
  input wire logic                   sample_valid_in,
  input wire logic                   adc_tick_out,
  input wire logic [2:0]             gain_exp_out,
  input wire logic [15:0]            result_out,
  input wire logic                   result_valid_out,
  input wire logic [4:0]             status_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);
  property p_lat;
    sample_valid_in |=> result_valid_out;
  endproperty
  a_lat: assert property (p_lat) else $error("result valid missing");
  property p_only;
    !sample_valid_in |=> !result_valid_out;
  endproperty
  a_only: assert property (p_only) else $error("result valid without sample");
  property p_ovr;
    sample_valid_in && sample_in.overrange |=> result_out == 16'hFFFF;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrange code missing");
  property p_noovr;
    sample_valid_in && !sample_in.overrange |=> result_out != 16'hFFFF;
  endproperty
  a_noovr: assert property (p_noovr) else $error("ordinary result hit overrange");
  property p_hold;
    !sample_valid_in |=> $stable(result_out);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved without sample");
  property p_prox;
    meas_kind_in inside {lpmc_pkg::LPMC_MEAS_PS1, lpmc_pkg::LPMC_MEAS_PS2,
      lpmc_pkg::LPMC_MEAS_PS3} |=> gain_exp_out == 3'h0;
  endproperty
  a_prox: assert property (p_prox) else $error("visible gain used for proximity");
  property p_tick;
    adc_tick_out && gain_exp_out == 3'h2 && $stable(gain_exp_out)
      |=> (!adc_tick_out || gain_exp_out != 3'h2) [*3];
  endproperty
  a_tick: assert property (p_tick) else $error("divide by four ticked early");
  property p_stat;
    $changed(status_out) |-> $past(result_valid_out);
  endproperty
  a_stat: assert property (p_stat) else $error("status changed without result");
endmodule : lpmc_checker

// ===== verification/lpmc_host_model.sv
// Host model that drives the register port of the measurement block.
`timescale 1ns/1ps
module lpmc_host_model (
  input  wire logic       clk_sys_in,
  output logic      [7:0] reg_addr_out,
  output logic      [7:0] reg_wdata_out,
  output logic            reg_wr_out,
  output logic            reg_rd_out,
  input  wire logic [7:0] reg_rdata_in
);
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_out <= a;
    // Reserved bits go out as zero at offsets 0x11 and 0x12; other offsets pass the data unmasked.
    reg_wdata_out <= (a == 8'h11) ? (d & 8'h07) : (a == 8'h12) ? (d & 8'h20) : d;
    reg_wr_out <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_out <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_out <= 1'b0;
    #1;
    d = reg_rdata_in;
  endtask : rd
  // The settle period lives outside this block, so its write lands on an unmapped offset.
  task automatic set_gain(input logic [2:0] g);
    wr(8'h10, {1'b0, ~g, 4'h0});
    wr(8'h11, {5'h00, g});
  endtask : set_gain
endmodule : lpmc_host_model

// ===== verification/testbench.sv
// Self-checking bench for the measurement path configuration block.
`timescale 1ns/1ps
module testbench;
  logic                   clk_sys_in = 1'b0;
  logic                   reset_in = 1'b1;
  logic [7:0]             a, wd, d, c, wv, rdata;
  logic                   wr, rd, sv = 1'b0;
  logic [2:0]             irg = 3'h0;
  logic                   irs = 1'b0;
  lpmc_pkg::lpmc_meas_e   mk = lpmc_pkg::LPMC_MEAS_VIS;
  lpmc_pkg::lpmc_sample_s smp = '0;
  lpmc_pkg::lpmc_limits_s lim = '{16'h2000, 16'h0800, 16'h1000, 16'hF000, 16'hF000};
  logic                   tick, hr, rv;
  logic [2:0]             ge;
  logic [15:0]            res, raw;
  logic [4:0]             st;
  int                     num_errors = 0, tests_run = 0, i, n, seed;
  logic [7:0]  ofs [9] = '{8'h11, 8'h12, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1C, 8'h10};
  logic [7:0]  rst [9] = '{8'h00, 8'h00, 8'h48, 8'h48, 8'h03, 8'h03, 8'h80, 8'h00, 8'h00};
  logic [7:0]  msk [9] = '{8'h07, 8'h20, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00};
  logic [15:0] pr [9] = '{16'h1018, 16'h1019, 16'h1019, 16'h1019, 16'h07E8, 16'h07E7,
    16'h07E7, 16'h2019, 16'h2019};
  logic [2:0]  ps [9] = '{3'h0, 3'h0, 3'h0, 3'h4, 3'h4, 3'h4, 3'h6, 3'h6, 3'h5};
  always #50 clk_sys_in = ~clk_sys_in;
  lpmc_host_model h (.clk_sys_in(clk_sys_in), .reg_addr_out(a), .reg_wdata_out(wd),
    .reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdata));
  // Built as an older sequencer revision, where infrared reuses the visible settings.
  lpmc_top #(.SEPARATE_IR_SETTINGS(1'b0)) dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .reg_addr_in(a), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .meas_kind_in(mk), .ir_gain_code_in(irg), .ir_high_span_in(irs), .sample_in(smp),
    .sample_valid_in(sv), .limits_in(lim), .adc_tick_out(tick), .gain_exp_out(ge),
    .high_range_out(hr), .result_out(res), .result_valid_out(rv), .status_out(st));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  function automatic logic [31:0] expand(input logic [7:0] k);
    logic [31:0] m;
    m = 32'h10 + k[3:0];
    if (k == 8'h00) return 32'h0;
    if (k[7:4] >= 4'h4) return m << (k[7:4] - 4'h4);
    return m >> (4'h4 - k[7:4]);
  endfunction : expand
  // Ordinary sums saturate one below the overrange code.
  function automatic logic [15:0] biased(input logic [15:0] r, input logic [7:0] k);
    logic [31:0] s;
    s = r + expand(k);
    return (s >= 32'hFFFF) ? 16'hFFFE : s[15:0];
  endfunction : biased
  task automatic send(input lpmc_pkg::lpmc_meas_e k, input logic o, input logic [15:0] r);
    @(posedge clk_sys_in);
    mk <= k;
    smp <= '{k, o, r};
    sv <= 1'b1;
    @(posedge clk_sys_in);
    sv <= 1'b0;
    #1;
    check(rv, 1'b1);
    repeat (2) @(posedge clk_sys_in);
    #1;
  endtask : send
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    num_errors++;
    report_and_stop();
  end
  initial begin
    seed = $urandom(32'h1E70);
    repeat (5) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    for (i = 0; i < 9; i++) begin
      h.rd(ofs[i], d);
      check(d, rst[i]);
    end
    for (i = 0; i < 9; i++) begin
      wv = 8'($urandom);
      h.wr(ofs[i], wv);
      h.rd(ofs[i], d);
      check(d, wv & msk[i]);
    end
    mk <= lpmc_pkg::LPMC_MEAS_VIS;
    for (i = 0; i < 8; i++) begin
      h.set_gain(i[2:0]);
      h.wr(8'h12, {2'b00, i[0], 5'h00});
      repeat (4) @(posedge clk_sys_in);
      #1;
      check(ge, i[2:0]);
      check(hr, i[0]);
      n = 0;
      repeat (128) begin
        @(posedge clk_sys_in);
        #1;
        n += tick;
      end
      check(n[15:0], 16'h80 >> i);
    end
    mk <= lpmc_pkg::LPMC_MEAS_IR;
    irg <= 3'h2;
    repeat (3) @(posedge clk_sys_in);
    #1;
    check(ge, 3'h7);
    check(hr, 1'b1);
    h.set_gain(3'h0);
    for (i = 0; i < 8; i++) begin
      c = (i < 3) ? 8'(8'h60 + 8'h10 * i) : 8'($urandom);
      raw = 16'($urandom);
      h.wr(8'h1A, c);
      send(lpmc_pkg::LPMC_MEAS_PS2, 1'b0, raw);
      check(res, biased(raw, c));
    end
    send(lpmc_pkg::LPMC_MEAS_PS2, 1'b1, 16'h1234);
    check(res, 16'hFFFF);
    h.wr(8'h1A, 8'h80);
    send(lpmc_pkg::LPMC_MEAS_PS2, 1'b0, 16'hFFF0);
    check(res, 16'hFFFE);
    // A second reset in mid-run must restore the registers and clear every filter history.
    reset_in <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    #1;
    check(res, 16'h0000);
    check(st, 5'h00);
    h.rd(8'h1A, d);
    check(d, 8'h80);
    @(posedge clk_sys_in);
    #1;
    check(rdata, 8'h00);
    h.wr(8'h1A, 8'h00);
    h.wr(8'h16, 8'h48);
    h.wr(8'h17, 8'h48);
    h.wr(8'h18, 8'h07);
    h.wr(8'h19, 8'h03);
    for (i = 0; i < 9; i++) begin
      send(i < 4 ? lpmc_pkg::LPMC_MEAS_PS1 : lpmc_pkg::LPMC_MEAS_VIS, 1'b0, pr[i]);
      check(st, {2'b00, ps[i]});
    end
    report_and_stop();
  end
endmodule : testbench
bind lpmc_top lpmc_checker chk (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
  .meas_kind_in(meas_kind_in), .sample_in(sample_in), .sample_valid_in(sample_valid_in),
  .adc_tick_out(adc_tick_out), .gain_exp_out(gain_exp_out), .result_out(result_out),
  .result_valid_out(result_valid_out), .status_out(status_out));
